// [core/tone_pkg.sv]
// Shared constants and types for the complementary tone output block.
// Assumes a classic Wishbone master with 32-bit data and byte addressing.
package tone_pkg;

  // Bus geometry.
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;

  // Register byte offsets.
  localparam logic [ADR_W-1:0] OFS_DIR    = 8'h00;
  localparam logic [ADR_W-1:0] OFS_DATA   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CONFIG = 8'h0C;

  // Bit positions inside the port registers.
  localparam int unsigned BIT_PIN_A = 0;
  localparam int unsigned BIT_PIN_B = 1;

  // Status register fields.
  localparam int unsigned STS_PIN_A_IN = 0;
  localparam int unsigned STS_PIN_B_IN = 1;
  localparam int unsigned STS_TONE     = 2;
  localparam int unsigned STS_RUNNING  = 3;

  // Configuration readback fields.
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_SRC_LSB  = 4;
  localparam int unsigned CFG_EXP_LSB  = 8;

  // Values after reset: both pins inputs, both data bits low.
  localparam logic [1:0] DIR_RST  = 2'h3;
  localparam logic [1:0] DATA_RST = 2'h0;

  // Divider exponent limits and the system oscillator prescale.
  localparam int unsigned DIV_EXP_MIN  = 2;
  localparam int unsigned DIV_EXP_MAX  = 9;
  localparam int unsigned SYS_PRE_W    = 2;
  localparam logic [SYS_PRE_W-1:0] SYS_PRE_LAST = 2'h3;

  // Nominal crystal frequency on the low-speed crystal input, in Hz.
  localparam int unsigned XTAL_HZ = 32768;

  // Pin arrangement, fixed at build time.
  typedef enum logic [2:0]
  {
    MODE_GPIO   = 3'b001,
    MODE_COMP   = 3'b010,
    MODE_SINGLE = 3'b100
  } pin_mode_e;

  // Source of the tone source clock, fixed at build time.
  typedef enum logic [2:0]
  {
    SRC_XTAL    = 3'b001,
    SRC_LFOSC   = 3'b010,
    SRC_SYSDIV4 = 3'b100
  } src_sel_e;

  // Wishbone request carried as one group.
  typedef struct packed
  {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_s;

  // One shared pin as seen from the block: level driven and enable (low drives).
  typedef struct packed
  {
    logic out;
    logic oe_n;
  } pin_drv_s;

endpackage

// [core/complementary_tone_output.sv]
// Tone generator with a complementary pin pair shared with two port pins.
// Assumes the oscillator inputs are synchronous levels sampled on mclk and
// that the pad logic resolves each shared pin from its level and enable.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - Build option picks GPIO, pair or single-pin arrangement.
// - Pair mode drives second pin as inverted tone.
// - Tone equals source clock over two to exponent.
// - Source is crystal, low-frequency oscillator or system/4.
// - Software registers never change the tone frequency.
// - In pair mode, data bit 0 gates both pins; low holds low.
// - Data bit 1 drives the inverted pin only while dir_bit0 is set.
// - Single-pin: pin B plain I/O, pin A gated tone.
// - Direction bit set means input, overriding tone.
// - Pin A stays usable as input when dir_bit0 set.
module complementary_tone_output #(
  parameter tone_pkg::pin_mode_e PIN_MODE = tone_pkg::MODE_COMP,
  parameter tone_pkg::src_sel_e  SRC_SEL  = tone_pkg::SRC_XTAL,
  parameter int unsigned         DIV_EXP  = 2
)
(
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire tone_pkg::wb_req_s           wb_req,
  output logic                             wb_ack_o,
  output logic [tone_pkg::DAT_W-1:0]       wb_dat_o,
  input  wire logic                        xtal_32k_in,
  input  wire logic                        internal_low_freq_osc,
  input  wire logic                        pin_tone_a_in,
  output logic                             pin_tone_a_out,
  output logic                             pin_tone_a_oe_n,
  input  wire logic                        pin_tone_b_in,
  output logic                             pin_tone_b_out,
  output logic                             pin_tone_b_oe_n
);
  import tone_pkg::*;

  localparam int unsigned CNT_W = DIV_EXP_MAX;

  // Software-visible port state.
  logic [1:0]             port_a_direction_reg_ff;
  logic [1:0]             port_a_data_reg_ff;

  // Bus answer state.
  logic                   ack_ff;
  logic [DAT_W-1:0]       rdat_ff;

  // Source tick generation.
  logic                   xtal_prev_ff;
  logic                   lfosc_prev_ff;
  logic [SYS_PRE_W-1:0]   sys_pre_ff;

  // Divider and tone.
  logic [CNT_W-1:0]       div_cnt_ff;
  logic                   tone_out_ff;

  // Registered pin drive.
  pin_drv_s               pin_a_ff;
  pin_drv_s               pin_b_ff;

  // Bus decode.
  wire                    bus_req;
  wire                    bus_wr;
  wire                    lane0_wr;
  wire                    hit_dir;
  wire                    hit_data;
  wire                    hit_status;
  wire                    hit_config;
  wire [DAT_W-1:0]        nxt_rdat;
  wire [1:0]              nxt_dir;
  wire [1:0]              nxt_data;

  // Source selection and divider.
  wire                    xtal_tick;
  wire                    lfosc_tick;
  wire                    sys_tick;
  wire                    src_tick;
  wire [CNT_W-1:0]        nxt_div_cnt;
  wire                    nxt_tone_out;
  wire                    tone_out;
  wire                    tone_out_n;

  // Pin selection.
  wire                    dir_bit0;
  wire                    dir_bit1;
  wire                    data_bit0;
  wire                    data_bit1;
  wire                    a_carries_tone;
  wire                    b_carries_tone;
  wire                    tone_enabled;
  pin_drv_s               nxt_pin_a;
  pin_drv_s               nxt_pin_b;

  // Status and configuration words.
  wire [DAT_W-1:0]        status_word;
  wire [DAT_W-1:0]        config_word;

  // ---------------------------------------------------------------------------
  // Wishbone slave. A request is answered one cycle after it is seen, and ack
  // drops in the following cycle so a request held through the ack cycle is not taken twice.
  // ---------------------------------------------------------------------------
  assign bus_req    = wb_req.cyc & wb_req.stb & ~ack_ff;
  assign bus_wr     = bus_req & wb_req.we;
  assign lane0_wr   = bus_wr & wb_req.sel[0];

  assign hit_dir    = (wb_req.adr == OFS_DIR);
  assign hit_data   = (wb_req.adr == OFS_DATA);
  assign hit_status = (wb_req.adr == OFS_STATUS);
  assign hit_config = (wb_req.adr == OFS_CONFIG);

  // Only the direction and data bits are writable; nothing written here reaches
  // the divider, so the frequency is fixed by the build parameters alone.
  assign nxt_dir  = (lane0_wr & hit_dir)  ? wb_req.dat[1:0] : port_a_direction_reg_ff;
  assign nxt_data = (lane0_wr & hit_data) ? wb_req.dat[1:0] : port_a_data_reg_ff;

  assign status_word = {
    {(DAT_W-4){1'b0}},
    tone_enabled,
    tone_out_ff,
    pin_tone_b_in,
    pin_tone_a_in
  };

  assign config_word = {
    {(DAT_W-12){1'b0}},
    4'(DIV_EXP),
    1'b0,
    SRC_SEL,
    1'b0,
    PIN_MODE
  };

  // Unmapped offsets read as zero and swallow writes, but are still answered.
  assign nxt_rdat = hit_dir    ? {{(DAT_W-2){1'b0}}, port_a_direction_reg_ff} :
                    hit_data   ? {{(DAT_W-2){1'b0}}, port_a_data_reg_ff}      :
                    hit_status ? status_word                                  :
                    hit_config ? config_word                                  :
                                 {DAT_W{1'b0}};

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= {DAT_W{1'b0}};
    end
    else
    begin
      ack_ff  <= bus_req;
      rdat_ff <= bus_req ? nxt_rdat : rdat_ff;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      port_a_direction_reg_ff <= DIR_RST;
      port_a_data_reg_ff      <= DATA_RST;
    end
    else
    begin
      port_a_direction_reg_ff <= nxt_dir;
      port_a_data_reg_ff      <= nxt_data;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ---------------------------------------------------------------------------
  // Tone source clock. The slow oscillators arrive as levels, so each rising
  // edge becomes one mclk tick; the system path is mclk itself divided by four.
  // ---------------------------------------------------------------------------
  assign xtal_tick  = xtal_32k_in & ~xtal_prev_ff;
  assign lfosc_tick = internal_low_freq_osc & ~lfosc_prev_ff;
  assign sys_tick   = (sys_pre_ff == SYS_PRE_LAST);

  assign src_tick = (SRC_SEL == SRC_XTAL)  ? xtal_tick  :
                    (SRC_SEL == SRC_LFOSC) ? lfosc_tick :
                                             sys_tick;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xtal_prev_ff  <= 1'b0;
      lfosc_prev_ff <= 1'b0;
      sys_pre_ff    <= {SYS_PRE_W{1'b0}};
    end
    else
    begin
      xtal_prev_ff  <= xtal_32k_in;
      lfosc_prev_ff <= internal_low_freq_osc;
      sys_pre_ff    <= sys_pre_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Divider. Stage DIV_EXP-1 of a free-running counter toggles every
  // 2^(DIV_EXP-1) ticks, giving source/2^DIV_EXP with equal high and low time.
  // The counter never stops with the pins, so re-enabling is glitch free but
  // the first period after enable may be short.
  // ---------------------------------------------------------------------------
  assign nxt_div_cnt  = src_tick ? div_cnt_ff + 1'b1 : div_cnt_ff;
  assign nxt_tone_out = div_cnt_ff[DIV_EXP-1];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt_ff  <= {CNT_W{1'b0}};
      tone_out_ff <= 1'b0;
    end
    else
    begin
      div_cnt_ff  <= nxt_div_cnt;
      tone_out_ff <= nxt_tone_out;
    end
  end

  assign tone_out   = tone_out_ff;
  assign tone_out_n = ~tone_out_ff;

  // ---------------------------------------------------------------------------
  // Pin selection. A set direction bit always releases the pin, whatever the
  // arrangement, so a tone pin can be turned into an input at run time.
  // ---------------------------------------------------------------------------
  assign dir_bit0  = port_a_direction_reg_ff[BIT_PIN_A];
  assign dir_bit1  = port_a_direction_reg_ff[BIT_PIN_B];
  assign data_bit0 = port_a_data_reg_ff[BIT_PIN_A];
  assign data_bit1 = port_a_data_reg_ff[BIT_PIN_B];

  assign a_carries_tone = (PIN_MODE != MODE_GPIO);
  // Pin B follows the tone only in pair mode and only while pin A is an output;
  // with pin A an input, pin B falls back to plain data.
  assign b_carries_tone = (PIN_MODE == MODE_COMP) & ~dir_bit0;
  assign tone_enabled   = a_carries_tone & ~dir_bit0 & data_bit0;

  always_comb
  begin
    nxt_pin_a.oe_n = dir_bit0;
    nxt_pin_b.oe_n = dir_bit1;
    if (a_carries_tone)
    begin
      nxt_pin_a.out = data_bit0 & tone_out;
    end
    else
    begin
      nxt_pin_a.out = data_bit0;
    end
    if (b_carries_tone)
    begin
      nxt_pin_b.out = data_bit0 & tone_out_n;
    end
    else
    begin
      nxt_pin_b.out = data_bit1;
    end
  end

  // Both pins are registered together so the pair never skews by a cycle.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_a_ff <= '{out: 1'b0, oe_n: 1'b1};
      pin_b_ff <= '{out: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      pin_a_ff <= nxt_pin_a;
      pin_b_ff <= nxt_pin_b;
    end
  end

  // Pair mode only works as intended once software clears both direction bits;
  // the block does not force them.
  assign pin_tone_a_out  = pin_a_ff.out;
  assign pin_tone_a_oe_n = pin_a_ff.oe_n;
  assign pin_tone_b_out  = pin_b_ff.out;
  assign pin_tone_b_oe_n = pin_b_ff.oe_n;

endmodule // complementary_tone_output

// [sim/tone_asserts.sv]
// Checker for the tone block: bus handshake, pin gating and tone half period.
// Sees only the top ports and shadows the port registers from bus writes.
`timescale 1ns/1ps
module tone_asserts
#(
  parameter tone_pkg::pin_mode_e PIN_MODE = tone_pkg::MODE_COMP,
  parameter tone_pkg::src_sel_e  SRC_SEL  = tone_pkg::SRC_XTAL,
  parameter int unsigned         DIV_EXP  = 2
)
(
  input wire logic                      mclk,
  input wire logic                      arst_n,
  input wire tone_pkg::wb_req_s         wb_req,
  input wire logic                      wb_ack_o,
  input wire logic [tone_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic                      xtal_32k_in,
  input wire logic                      internal_low_freq_osc,
  input wire logic                      pin_tone_a_in,
  input wire logic                      pin_tone_a_out,
  input wire logic                      pin_tone_a_oe_n,
  input wire logic                      pin_tone_b_in,
  input wire logic                      pin_tone_b_out,
  input wire logic                      pin_tone_b_oe_n
);
  import tone_pkg::*;
  localparam logic [9:0] HALF = 10'(1 << (DIV_EXP - 1));
  logic [1:0] dir_ff;
  logic [1:0] dat_ff;
  logic [9:0] cnt_ff;
  logic       src_ff;
  logic       a_ff;
  logic       b_ff;
  logic       seen_ff;
  wire        take = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  wire        wr   = take & wb_req.we & wb_req.sel[0];
  wire        rd_dir = take & ~wb_req.we & (wb_req.adr == OFS_DIR);
  wire        src  = (SRC_SEL == SRC_XTAL) ? xtal_32k_in : internal_low_freq_osc;
  wire        tick = src & ~src_ff;
  wire        en0  = ~dir_ff[0] & dat_ff[0];
  wire        edge_t = (pin_tone_a_out ^ a_ff) & (pin_tone_b_out ^ b_ff) & (pin_tone_a_out ^ pin_tone_b_out);
  wire        live = ~pin_tone_a_oe_n & ~pin_tone_b_oe_n & (pin_tone_a_out | pin_tone_b_out);
  wire [1:0]  nxt_dir = (wr && wb_req.adr == OFS_DIR) ? wb_req.dat[1:0] : dir_ff;
  wire [1:0]  nxt_dat = (wr && wb_req.adr == OFS_DATA) ? wb_req.dat[1:0] : dat_ff;
  wire [9:0]  nxt_cnt = edge_t ? 10'(tick) : cnt_ff + 10'(tick);
  // A gap in gating or a pin turned to input voids the half-period count.
  wire        nxt_seen = live & (seen_ff | edge_t);
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      dir_ff  <= DIR_RST;
      dat_ff  <= DATA_RST;
      cnt_ff  <= 10'h000;
      {src_ff, a_ff, b_ff, seen_ff} <= 4'h0;
    end
    else
    begin
      dir_ff  <= nxt_dir;
      dat_ff  <= nxt_dat;
      cnt_ff  <= nxt_cnt;
      {src_ff, a_ff, b_ff, seen_ff} <= {src, pin_tone_a_out, pin_tone_b_out, nxt_seen};
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_taken; take; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_pulse: assert property (s_taken |=> s_pulse)
    else $error("ack is not a one-cycle pulse after a request");
  a_oe_a: assert property (pin_tone_a_oe_n == $past(dir_ff[0]))
    else $error("pin A enable does not follow its direction bit");
  a_oe_b: assert property (pin_tone_b_oe_n == $past(dir_ff[1]))
    else $error("pin B enable does not follow its direction bit");
  a_gate_low: assert property (PIN_MODE != MODE_GPIO && !$past(dat_ff[0]) |-> !pin_tone_a_out)
    else $error("pin A drives while gated off");
  a_pair_inverse: assert property (PIN_MODE == MODE_COMP && $past(en0)
    |-> pin_tone_a_out != pin_tone_b_out)
    else $error("pair pins are not complementary");
  a_plain_b: assert property (PIN_MODE != MODE_COMP || $past(dir_ff[0])
    |-> pin_tone_b_out == $past(dat_ff[1]))
    else $error("pin B is not plain data");
  a_tone_half: assert property (PIN_MODE == MODE_COMP && SRC_SEL != SRC_SYSDIV4 && edge_t && seen_ff
    |-> cnt_ff == HALF)
    else $error("tone half period has the wrong tick count");
  a_read_dir: assert property (wb_ack_o && $past(rd_dir) |-> wb_dat_o == 32'(dir_ff))
    else $error("direction register reads back wrong");
endmodule // tone_asserts

bind complementary_tone_output tone_asserts #(.PIN_MODE(PIN_MODE), .SRC_SEL(SRC_SEL), .DIV_EXP(DIV_EXP)) u_asserts (
  .mclk(mclk), .arst_n(arst_n), .wb_req(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .xtal_32k_in(xtal_32k_in), .internal_low_freq_osc(internal_low_freq_osc), .pin_tone_a_in(pin_tone_a_in),
  .pin_tone_a_out(pin_tone_a_out), .pin_tone_a_oe_n(pin_tone_a_oe_n), .pin_tone_b_in(pin_tone_b_in),
  .pin_tone_b_out(pin_tone_b_out), .pin_tone_b_oe_n(pin_tone_b_oe_n));

// [sim/buzzer_model.sv]
// Far-side model: piezo load plus an external driver on released pins.
// Assumes the pad resolves each pin from the block's level and enable.
`timescale 1ns/1ps
module buzzer_model
(
  input  wire logic a_out,
  input  wire logic a_oe_n,
  input  wire logic b_out,
  input  wire logic b_oe_n,
  input  wire logic ext_a,
  input  wire logic ext_b,
  output logic      a_in,
  output logic      b_in
);
  // A released pin follows the external driver, so input reads mean something.
  assign a_in = a_oe_n ? ext_a : a_out;
  assign b_in = b_oe_n ? ext_b : b_out;
endmodule // buzzer_model

// [sim/tb.sv]
// Self-checking bench for the tone block in pair mode on the crystal source,
// with a second single-pin instance on the system/4 source sharing the bus.
// Assumes the bound checker and the buzzer model beside the block.
`timescale 1ns/1ps
module tb;
  import tone_pkg::*;
  localparam int unsigned DIV = 2;
  localparam int unsigned XT_HALF = 3;
  // Two tone periods: each tick takes 2*XT_HALF cycles, a period 2^DIV ticks.
  localparam int unsigned WIN = 4 * XT_HALF * (1 << DIV);
  // Single-pin instance: a tick every prescaler wrap, two tone periods counted.
  localparam int unsigned SDIV = 3;
  localparam int unsigned SYS_WIN = 2 * (SYS_PRE_LAST + 1) * (1 << SDIV);
  logic        s_a_out, s_a_oe_n, s_b_out, s_b_oe_n;
  logic        mclk, arst_n, xtal, ext_a, ext_b, a_in, b_in, ack, a_out, a_oe_n, b_out, b_oe_n;
  logic [31:0] rdat, rd;
  wb_req_s     req;
  int          num_errors, checks_done, cyc_cnt, xt_cnt;
  complementary_tone_output #(.PIN_MODE(MODE_COMP), .SRC_SEL(SRC_XTAL), .DIV_EXP(DIV)) dut (
    .mclk(mclk), .arst_n(arst_n), .wb_req(req), .wb_ack_o(ack), .wb_dat_o(rdat), .xtal_32k_in(xtal),
    .internal_low_freq_osc(1'b0), .pin_tone_a_in(a_in), .pin_tone_a_out(a_out), .pin_tone_a_oe_n(a_oe_n),
    .pin_tone_b_in(b_in), .pin_tone_b_out(b_out), .pin_tone_b_oe_n(b_oe_n));
  complementary_tone_output #(.PIN_MODE(MODE_SINGLE), .SRC_SEL(SRC_SYSDIV4), .DIV_EXP(SDIV)) dut_single (
    .mclk(mclk), .arst_n(arst_n), .wb_req(req), .wb_ack_o(), .wb_dat_o(), .xtal_32k_in(xtal),
    .internal_low_freq_osc(1'b0), .pin_tone_a_in(s_a_out), .pin_tone_a_out(s_a_out), .pin_tone_a_oe_n(s_a_oe_n),
    .pin_tone_b_in(s_b_out), .pin_tone_b_out(s_b_out), .pin_tone_b_oe_n(s_b_oe_n));
  buzzer_model bz (.a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out), .b_oe_n(b_oe_n), .ext_a(ext_a),
    .ext_b(ext_b), .a_in(a_in), .b_in(b_in));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    xt_cnt <= (xt_cnt == XT_HALF - 1) ? 0 : xt_cnt + 1;
    if (xt_cnt == XT_HALF - 1)
      xtal <= ~xtal;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000)
    begin
      num_errors++;
      report_and_stop;
    end
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // The request stands until ack is sampled; one idle edge follows the release.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] r);
    req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
    @(posedge mclk);
    while (ack !== 1'b1)
      @(posedge mclk);
    r = rdat;
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic measure(input logic on, input logic [31:0] exp_hi);
    logic [31:0] hi;
    hi = '0;
    repeat (WIN)
    begin
      @(posedge mclk);
      hi = hi + 32'(a_out);
      check("pin_b_level", 32'(b_out), on ? 32'(!a_out) : 32'h0);
    end
    check("tone_high_cycles", hi, exp_hi);
  endtask
  task t_reset;
    check("enables", 32'({a_oe_n, b_oe_n}), 32'h3);
    wb(1'b0, OFS_DIR, 32'h0, rd);
    check("dir_reset", rd, 32'(DIR_RST));
    wb(1'b0, OFS_DATA, 32'h0, rd);
    check("data_reset", rd, 32'(DATA_RST));
  endtask
  task t_pair;
    wb(1'b1, OFS_DIR, 32'h0, rd);
    wb(1'b1, OFS_DATA, 32'h3, rd);
    check("enables_on", 32'({a_oe_n, b_oe_n}), 32'h0);
    measure(1'b1, WIN / 2);
  endtask
  task t_gate;
    wb(1'b1, OFS_DATA, 32'h2, rd);
    measure(1'b0, 32'h0);
  endtask
  task t_override;
    wb(1'b1, OFS_DIR, 32'h1, rd);
    wb(1'b1, OFS_DATA, 32'h3, rd);
    check("pin_a_enable", 32'(a_oe_n), 32'h1);
    check("pin_b_data", 32'(b_out), 32'h1);
    ext_a <= 1'b1;
    repeat (3) @(posedge mclk);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check("pin_a_in_high", 32'(rd[STS_PIN_A_IN]), 32'h1);
    check("pin_b_in_data", 32'(rd[STS_PIN_B_IN]), 32'h1);
    check("tone_not_running", 32'(rd[STS_RUNNING]), 32'h0);
    ext_a <= 1'b0;
    repeat (3) @(posedge mclk);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check("pin_a_in_low", 32'(rd[STS_PIN_A_IN]), 32'h0);
  endtask
  task t_ignored;
    wb(1'b1, OFS_CONFIG, 32'hFFFFFFFF, rd);
    wb(1'b1, OFS_STATUS, 32'hFFFFFFFF, rd);
    wb(1'b1, 8'h10, 32'h3, rd);
    wb(1'b0, 8'h10, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    wb(1'b0, OFS_CONFIG, 32'h0, rd);
    check("config", rd, 32'(MODE_COMP) | (32'(SRC_XTAL) << CFG_SRC_LSB) | (32'(DIV) << CFG_EXP_LSB));
    wb(1'b1, OFS_DIR, 32'h0, rd);
    wb(1'b1, OFS_DATA, 32'h1, rd);
    measure(1'b1, WIN / 2);
  endtask
  task automatic t_single;
    logic [31:0] hi;
    hi = '0;
    wb(1'b1, OFS_DIR, 32'h0, rd);
    wb(1'b1, OFS_DATA, 32'h1, rd);
    check("single_b_plain", 32'({s_a_oe_n, s_b_oe_n, s_b_out}), 32'h0);
    repeat (SYS_WIN)
    begin
      @(posedge mclk);
      hi = hi + 32'(s_a_out);
    end
    check("single_high_cycles", hi, SYS_WIN / 2);
    wb(1'b1, OFS_DATA, 32'h2, rd);
    check("single_gated", 32'({s_a_out, s_b_out}), 32'h1);
  endtask
  initial
  begin
    {arst_n, xtal, ext_a, ext_b} = 4'h0;
    req = '0;
    {num_errors, checks_done, cyc_cnt, xt_cnt} = {4{32'h0}};
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_pair;
    t_gate;
    t_override;
    t_ignored;
    t_single;
    report_and_stop;
  end
endmodule // tb
